// File: hw/n2scd_defines.svh
// Register offsets, field positions, reset values and codes of the slave command decoder.
`ifndef N2SCD_DEFINES_SVH
`define N2SCD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define N2SCD_OFF_REQ   12'h000
`define N2SCD_OFF_RESP  12'h004
`define N2SCD_OFF_DATA  12'h008
`define N2SCD_OFF_BOWR  12'h00c
`define N2SCD_OFF_RUNW  12'h010
`define N2SCD_OFF_UNIW  12'h014
`define N2SCD_OFF_FSLO  12'h018
`define N2SCD_OFF_FSHI  12'h01c
`define N2SCD_OFF_GRP   12'h020
`define N2SCD_OFF_PFC   12'h024
`define N2SCD_OFF_STAT  12'h028

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define N2SCD_REQ_CMD_LSB    0
`define N2SCD_REQ_SUB_LSB    4
`define N2SCD_REQ_REGION_LSB 8
`define N2SCD_REQ_POINT_LSB  12
`define N2SCD_REQ_ATTR_LSB   20
`define N2SCD_BOWR_VAL_BIT   8
`define N2SCD_RUN_RESET_BIT  15
`define N2SCD_UNI_RELAY_BIT  8

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define N2SCD_WORD_RST   16'h0000
`define N2SCD_FSEL_RST   48'h0000_0000_0000
`define N2SCD_ERR_CMD    8'h01
`define N2SCD_ERR_ATTR   8'h11
`define N2SCD_ERR_NONE   8'h00
`define N2SCD_FSEL_LINK  8'h1b
`define N2SCD_AI_PT_MAX  8'h06
`define N2SCD_BI_PT_MAX  8'h11
`define N2SCD_AO_PT_MAX  8'h08
`define N2SCD_BO_PT_MAX  8'h12
`define N2SCD_BO_DP_PT   8'h14
`define N2SCD_BO_RST_PT  8'h0d

`endif

// File: hw/n2scd_pkg.sv
// Types shared by the slave command decoder modules.
package n2scd_pkg;

  typedef enum logic [1:0] {
    N2SCD_ST_IDLE = 2'b01,
    N2SCD_ST_BUSY = 2'b10
  } n2scd_state_t;

  typedef enum logic [2:0] {
    N2SCD_KIND_NONE       = 3'h0,
    N2SCD_KIND_BYTE       = 3'h1,
    N2SCD_KIND_BYTE_FLOAT = 3'h2,
    N2SCD_KIND_FLOAT      = 3'h3,
    N2SCD_KIND_INT_ZERO   = 3'h4
  } n2scd_kind_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  err;
    n2scd_kind_t kind;
  } n2scd_resp_t;

endpackage : n2scd_pkg

// File: hw/n2scd_bo_if.sv
// Carrier between the decoder core and the binary output point map.
`timescale 1ns/10ps
interface n2scd_bo_if;
  logic       wr_en;
  logic [7:0] wr_point;
  logic       wr_value;
  logic [7:0] rd_point;
  logic       rd_bit;

  modport ctrl (output wr_en, output wr_point, output wr_value, output rd_point,
                input rd_bit);
  modport map  (input wr_en, input wr_point, input wr_value, input rd_point,
                output rd_bit);
endinterface : n2scd_bo_if

// File: hw/n2scd_point_map.sv
// Binary output point map onto the run command and universal output words.
`timescale 1ns/10ps
`include "n2scd_defines.svh"
module n2scd_point_map (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Point access
  n2scd_bo_if.map          bo,
  // Terminal function selects, one byte per terminal
  input  wire logic [47:0] function_select_in,
  // Words towards the drive
  output logic      [15:0] run_command_word_out,
  output logic      [15:0] universal_output_word_out,
  output logic      [15:0] universal_output_raw_out,
  output logic             data_protect_setting_out
);

  logic [15:0] run_command_word;
  logic [15:0] universal_output_word;
  logic        data_protect_setting;
  logic [5:0]  term_linked;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_command_word <= `N2SCD_WORD_RST;
    end else if (bo.wr_en) begin
      if (bo.wr_point >= 8'h01 && bo.wr_point <= 8'h09) begin
        run_command_word[bo.wr_point[3:0] - 4'h1] <= bo.wr_value;
      end else if (bo.wr_point == `N2SCD_BO_RST_PT) begin
        run_command_word[`N2SCD_RUN_RESET_BIT] <= bo.wr_value;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      universal_output_word <= `N2SCD_WORD_RST;
    end else if (bo.wr_en) begin
      if (bo.wr_point >= 8'h0e && bo.wr_point <= 8'h12) begin
        universal_output_word[bo.wr_point[3:0] - 4'he] <= bo.wr_value;
      end else if (bo.wr_point == 8'h13) begin
        universal_output_word[`N2SCD_UNI_RELAY_BIT] <= bo.wr_value;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_protect_setting <= 1'b0;
    end else if (bo.wr_en && bo.wr_point == `N2SCD_BO_DP_PT) begin
      data_protect_setting <= bo.wr_value;
    end
  end

  // A terminal follows the link only while its select holds the link value.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      term_linked[i] = (function_select_in[i*8 +: 8] == `N2SCD_FSEL_LINK);
    end
  end

  always_comb begin
    bo.rd_bit = 1'b0;
    if (bo.rd_point >= 8'h01 && bo.rd_point <= 8'h09) begin
      bo.rd_bit = run_command_word[bo.rd_point[3:0] - 4'h1];
    end else if (bo.rd_point == `N2SCD_BO_RST_PT) begin
      bo.rd_bit = run_command_word[`N2SCD_RUN_RESET_BIT];
    end else if (bo.rd_point >= 8'h0e && bo.rd_point <= 8'h12) begin
      bo.rd_bit = universal_output_word[bo.rd_point[3:0] - 4'he];
    end else if (bo.rd_point == 8'h13) begin
      bo.rd_bit = universal_output_word[`N2SCD_UNI_RELAY_BIT];
    end else if (bo.rd_point == `N2SCD_BO_DP_PT) begin
      bo.rd_bit = data_protect_setting;
    end
  end

  assign run_command_word_out      = run_command_word;
  assign universal_output_raw_out  = universal_output_word;
  assign data_protect_setting_out  = data_protect_setting;
  assign universal_output_word_out = {7'h00,
                                      universal_output_word[8] & term_linked[5],
                                      3'h0,
                                      universal_output_word[4:0] & term_linked[4:0]};

endmodule : n2scd_point_map

// File: hw/n2scd_top.sv
// Slave command decoder with APB register access and binary output point map.
//
// Notes on behaviour
// - Supported requests get ACK; others get NAK with error code 01 or 11.
// - Command 0 acknowledges subcommands 0, 4, 5 and 9 and refuses 1 and 8 with 01.
// - Analog input reads on points 0-6 acknowledge attributes 1, 2 and 3.
// - AI attributes 8-12 ACK float, 4-7 and 13-14 NAK 11; BI 0-17 ACK 1-2, NAK 11 on 3-4.
// - BO points 1-9 set run word bits 0-8, 13 sets bit 15, 20 sets data protect.
// - BO points 14-19 set universal bits 0-4 and 8, effective only with select 27.
// - Group codes 0x02 to 0x29 decode, with 0x00, 0x09, 0x0B, 0x0C, 0x13, 0x15, 0x16, 0x1B, 0x1C, 0x1F, 0x21-0x23, 0x26, 0x2A reserved.
// - A response is produced only after a request is received; the host is sole master.
// - BO minimum on, minimum off and max cycles reads ACK with value zero.
`timescale 1ns/10ps
`include "n2scd_defines.svh"
module n2scd_top (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Drive words
  output logic      [15:0] run_command_word_out,
  output logic      [15:0] universal_output_word_out,
  output logic             data_protect_setting_out,
  // Response event
  output logic             response_ready_out
);

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  function automatic n2scd_pkg::n2scd_resp_t decode_req(input logic [3:0] cmd,
                                                        input logic [3:0] sub,
                                                        input logic [3:0] region,
                                                        input logic [7:0] pt,
                                                        input logic [7:0] attr);
    n2scd_pkg::n2scd_resp_t r;
    r.ack  = 1'b0;
    r.err  = `N2SCD_ERR_CMD;
    r.kind = n2scd_pkg::N2SCD_KIND_NONE;
    case (cmd)
      4'h0: begin
        case (sub)
          4'h0, 4'h4, 4'h5, 4'h9: r.ack = 1'b1;
          default: r.err = `N2SCD_ERR_CMD;
        endcase
      end
      4'h1: begin
        r.err = `N2SCD_ERR_ATTR;
        case (region)
          4'h1: begin
            if (pt <= `N2SCD_AI_PT_MAX) begin
              case (attr)
                8'h01: r.kind = n2scd_pkg::N2SCD_KIND_BYTE;
                8'h02: r.kind = n2scd_pkg::N2SCD_KIND_BYTE_FLOAT;
                8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c:
                  r.kind = n2scd_pkg::N2SCD_KIND_FLOAT;
                default: r.kind = n2scd_pkg::N2SCD_KIND_NONE;
              endcase
            end
          end
          4'h2: begin
            if (pt <= `N2SCD_BI_PT_MAX && (attr == 8'h01 || attr == 8'h02)) begin
              r.kind = n2scd_pkg::N2SCD_KIND_BYTE;
            end
          end
          4'h3: begin
            if (pt <= `N2SCD_AO_PT_MAX) begin
              case (attr)
                8'h01, 8'h02: r.kind = n2scd_pkg::N2SCD_KIND_BYTE;
                8'h03:        r.kind = n2scd_pkg::N2SCD_KIND_FLOAT;
                default:      r.kind = n2scd_pkg::N2SCD_KIND_NONE;
              endcase
            end
          end
          4'h4: begin
            if (pt <= `N2SCD_BO_PT_MAX) begin
              case (attr)
                8'h01, 8'h02:        r.kind = n2scd_pkg::N2SCD_KIND_BYTE;
                8'h03, 8'h04, 8'h05: r.kind = n2scd_pkg::N2SCD_KIND_INT_ZERO;
                default:             r.kind = n2scd_pkg::N2SCD_KIND_NONE;
              endcase
            end
          end
          default: r.err = `N2SCD_ERR_CMD;
        endcase
        if (r.kind != n2scd_pkg::N2SCD_KIND_NONE) begin
          r.ack = 1'b1;
        end
      end
      default: r.err = `N2SCD_ERR_CMD;
    endcase
    if (r.ack) begin
      r.err = `N2SCD_ERR_NONE;
    end
    return r;
  endfunction : decode_req

  function automatic logic group_known(input logic [7:0] code);
    logic ok;
    ok = (code >= 8'h02 && code <= 8'h29);
    case (code)
      8'h09, 8'h0b, 8'h0c, 8'h13, 8'h15, 8'h16, 8'h1b, 8'h1c, 8'h1f,
      8'h21, 8'h22, 8'h23, 8'h26: ok = 1'b0;
      default: ok = ok;
    endcase
    return ok;
  endfunction : group_known

  // --------------------------------------------------------------------------
  // State and registers
  // --------------------------------------------------------------------------
  n2scd_pkg::n2scd_state_t state;
  n2scd_pkg::n2scd_resp_t  resp;
  n2scd_bo_if              bo ();
  logic [27:0] req;
  logic        resp_valid;
  logic [7:0]  resp_data;
  logic [47:0] function_select;
  logic [7:0]  group_code;
  logic [15:0] param_code;
  logic [31:0] prdata;
  logic [15:0] uni_raw;
  logic        wr_acc;
  logic        rd_setup;
  logic        rd_acc;
  logic        addr_ok;
  logic        req_take;

  assign wr_acc   = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign rd_acc   = psel_in & penable_in & ~pwrite_in;
  assign addr_ok  = (paddr_in[1:0] == 2'h0) && (paddr_in <= `N2SCD_OFF_STAT);
  assign req_take = wr_acc && paddr_in == `N2SCD_OFF_REQ && state == n2scd_pkg::N2SCD_ST_IDLE;

  // --------------------------------------------------------------------------
  // Request sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= n2scd_pkg::N2SCD_ST_IDLE;
    end else begin
      case (state)
        n2scd_pkg::N2SCD_ST_IDLE: if (req_take) state <= n2scd_pkg::N2SCD_ST_BUSY;
        n2scd_pkg::N2SCD_ST_BUSY: state <= n2scd_pkg::N2SCD_ST_IDLE;
        default:                  state <= n2scd_pkg::N2SCD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req <= 28'h0000000;
    end else if (req_take) begin
      req <= pwdata_in[27:0];
    end
  end

  // A new answer wins over a read that clears the previous one.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp       <= '0;
      resp_data  <= 8'h00;
      resp_valid <= 1'b0;
    end else if (state == n2scd_pkg::N2SCD_ST_BUSY) begin
      resp <= decode_req(req[`N2SCD_REQ_CMD_LSB +: 4], req[`N2SCD_REQ_SUB_LSB +: 4],
                         req[`N2SCD_REQ_REGION_LSB +: 4], req[`N2SCD_REQ_POINT_LSB +: 8],
                         req[`N2SCD_REQ_ATTR_LSB +: 8]);
      resp_data  <= (req[`N2SCD_REQ_REGION_LSB +: 4] == 4'h4 &&
                     req[`N2SCD_REQ_ATTR_LSB +: 8] == 8'h02) ? {7'h00, bo.rd_bit}
                                                            : 8'h00;
      resp_valid <= 1'b1;
    end else if (rd_acc && paddr_in == `N2SCD_OFF_RESP) begin
      resp_valid <= 1'b0;
    end
  end

  assign bo.rd_point = req[`N2SCD_REQ_POINT_LSB +: 8];
  assign bo.wr_en    = wr_acc && paddr_in == `N2SCD_OFF_BOWR;
  assign bo.wr_point = pwdata_in[7:0];
  assign bo.wr_value = pwdata_in[`N2SCD_BOWR_VAL_BIT];

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      function_select <= `N2SCD_FSEL_RST;
    end else if (wr_acc && paddr_in == `N2SCD_OFF_FSLO) begin
      function_select[31:0] <= pwdata_in;
    end else if (wr_acc && paddr_in == `N2SCD_OFF_FSHI) begin
      function_select[47:32] <= pwdata_in[15:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      group_code <= 8'h00;
    end else if (wr_acc && paddr_in == `N2SCD_OFF_GRP) begin
      group_code <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      param_code <= 16'h0000;
    end else if (wr_acc && paddr_in == `N2SCD_OFF_PFC) begin
      param_code <= pwdata_in[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr_in)
        `N2SCD_OFF_REQ:  prdata <= {4'h0, req};
        `N2SCD_OFF_RESP: prdata <= {13'h0000, resp.kind, resp.err, 5'h00,
                                    resp_valid & ~resp.ack, resp_valid & resp.ack,
                                    resp_valid};
        `N2SCD_OFF_DATA: prdata <= {24'h000000, resp_data};
        `N2SCD_OFF_RUNW: prdata <= {16'h0000, run_command_word_out};
        `N2SCD_OFF_UNIW: prdata <= {uni_raw, universal_output_word_out};
        `N2SCD_OFF_FSLO: prdata <= function_select[31:0];
        `N2SCD_OFF_FSHI: prdata <= {16'h0000, function_select[47:32]};
        `N2SCD_OFF_GRP:  prdata <= {23'h000000, group_known(group_code), group_code};
        `N2SCD_OFF_PFC:  prdata <= {16'h0000, param_code};
        `N2SCD_OFF_STAT: prdata <= {30'h00000000, data_protect_setting_out,
                                    state == n2scd_pkg::N2SCD_ST_BUSY};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  assign prdata_out         = prdata;
  assign pready_out         = 1'b1;
  assign pslverr_out        = psel_in & penable_in & ~addr_ok;
  assign response_ready_out = resp_valid;

  // --------------------------------------------------------------------------
  // Point map
  // --------------------------------------------------------------------------
  n2scd_point_map u_point_map (
    .ref_clk_in                (ref_clk_in),
    .reset_n_in                (reset_n_in),
    .bo                        (bo),
    .function_select_in        (function_select),
    .run_command_word_out      (run_command_word_out),
    .universal_output_word_out (universal_output_word_out),
    .universal_output_raw_out  (uni_raw),
    .data_protect_setting_out  (data_protect_setting_out)
  );

endmodule : n2scd_top

// File: verif/n2scd_checker.sv
// Port assertions of the slave command decoder.
`timescale 1ns/10ps
`include "n2scd_defines.svh"
module n2scd_checker (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  // APB slave
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Drive words and response event
  input wire logic [15:0] run_command_word_out,
  input wire logic [15:0] universal_output_word_out,
  input wire logic        data_protect_setting_out,
  input wire logic        response_ready_out
);
  // ----------
  // Relations
  // ----------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic       acc = psel_in & penable_in & pwrite_in;
  wire logic       req_wr = acc & (paddr_in == `N2SCD_OFF_REQ);
  wire logic       bo_wr = acc & (paddr_in == `N2SCD_OFF_BOWR);
  wire logic [7:0] pt = pwdata_in[7:0];

  req_answered_a: assert property (req_wr |-> ##2 response_ready_out)
    else $error("request not answered in time");
  resp_has_cause_a: assert property ($rose(response_ready_out) |-> $past(req_wr, 2))
    else $error("response without request");
  run_bit_set_a: assert property (bo_wr && pt inside {[8'h01:8'h09]} |=>
    run_command_word_out[$past(pt) - 8'h01] == $past(pwdata_in[8]))
    else $error("run word bit wrong");
  run_reset_bit_a: assert property (bo_wr && pt == 8'h0d |=>
    run_command_word_out[15] == $past(pwdata_in[8])) else $error("reset bit wrong");
  reserved_hold_a: assert property (bo_wr && pt inside {[8'h0a:8'h0c]} |=>
    $stable(run_command_word_out)) else $error("reserved point changed word");
  protect_set_a: assert property (bo_wr && pt == 8'h14 |=>
    data_protect_setting_out == $past(pwdata_in[8])) else $error("protect wrong");
  run_spare_a: assert property (run_command_word_out[14:9] == 6'h00)
    else $error("run word spare bits set");
  uni_spare_a: assert property (universal_output_word_out[15:9] == 7'h00 &&
    universal_output_word_out[7:5] == 3'h0) else $error("universal spare bits set");
  uni_cause_a: assert property ($rose(universal_output_word_out[0]) |->
    $past(acc && (paddr_in == `N2SCD_OFF_BOWR || paddr_in == `N2SCD_OFF_FSLO)))
    else $error("universal bit rose without cause");
  unmapped_err_a: assert property (psel_in && penable_in && paddr_in > 12'h028
    |-> pslverr_out) else $error("unmapped access not refused");
  cover property (req_wr ##2 response_ready_out);
  cover property (bo_wr && pt == 8'h0d);
  cover property ($rose(universal_output_word_out[8]));
endmodule : n2scd_checker

bind n2scd_top n2scd_checker i_n2scd_checker (.ref_clk_in, .reset_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .run_command_word_out, .universal_output_word_out, .data_protect_setting_out,
  .response_ready_out);

// File: verif/n2scd_host_model.sv
// Host controller model issuing register transfers to the decoder.
`timescale 1ns/10ps
`include "n2scd_defines.svh"
module n2scd_host_model (
  // Clock
  input  wire logic        ref_clk_in,
  // APB master
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  // ----------
  // Transfers
  // ----------
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end

  // One transfer at a time; the host is the only master on the bus.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge ref_clk_in);
    end
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~d;
    @(posedge ref_clk_in);
  endtask : xfer

  // A request is sent, then the answer is polled until it is valid or 8 reads have been made.
  task automatic request(input logic [27:0] f, output logic [31:0] resp);
    logic e;
    int   n;
    xfer(1'b1, `N2SCD_OFF_REQ, {4'h0, f}, resp, e);
    resp = 32'h0;
    for (n = 0; n < 8 && resp[0] !== 1'b1; n++) begin
      xfer(1'b0, `N2SCD_OFF_RESP, 32'h0, resp, e);
    end
  endtask : request

  // The function code number is loaded, then read back from the same register.
  task automatic set_code(input logic [15:0] fc, output logic [31:0] rd);
    logic e;
    xfer(1'b1, `N2SCD_OFF_PFC, {16'h0, fc}, rd, e);
    xfer(1'b0, `N2SCD_OFF_PFC, 32'h0, rd, e);
  endtask : set_code
endmodule : n2scd_host_model

// File: verif/testbench.sv
// Self-checking testbench of the slave command decoder.
`timescale 1ns/10ps
`include "n2scd_defines.svh"
module testbench;
  // ----------
  // Signals
  // ----------
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, exp_resp;
  logic [15:0] run_command_word_out, universal_output_word_out;
  logic        data_protect_setting_out, response_ready_out, err, ack, known;
  logic [7:0]  p;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [39:0] DEC [30] = '{
    40'h000_0000000, 40'h001_0000010, 40'h000_0000040, 40'h000_0000050,
    40'h001_0000080, 40'h000_0000090, 40'h001_0000020, 40'h100_0106101,
    40'h200_0206101, 40'h300_0306101, 40'h011_0406101, 40'h011_0706101,
    40'h300_0806101, 40'h300_0c06101, 40'h011_0d06101, 40'h011_0e06101,
    40'h100_0100101, 40'h011_0107101, 40'h100_0111201, 40'h100_0211201,
    40'h011_0311201, 40'h011_0411201, 40'h400_0312401, 40'h400_0412401,
    40'h400_0512401, 40'h011_0612401, 40'h001_0100501, 40'h001_0000003,
    40'h011_0112201, 40'h300_0308301};

  always #2 ref_clk_in = ~ref_clk_in;

  n2scd_top i_n2scd_top (.ref_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .run_command_word_out,
    .universal_output_word_out, .data_protect_setting_out, .response_ready_out);
  n2scd_host_model i_n2scd_host_model (.ref_clk_in(ref_clk_in), .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
    .pwdata_out(pwdata_in), .prdata_in(prdata_out), .pready_in(pready_out),
    .pslverr_in(pslverr_out));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_n2scd_host_model.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input string what);
    i_n2scd_host_model.xfer(1'b0, a, 32'h0, rd, err);
    check(rd & m, exp, what);
  endtask : rdchk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk_in);
    check({16'h0, run_command_word_out}, 32'h0, "run word in reset");
    reset_n_in <= 1'b1;
    foreach (DEC[i]) begin
      check({31'h0, response_ready_out}, 32'h0, "answer before request");
      i_n2scd_host_model.request(DEC[i][27:0], rd);
      ack = (DEC[i][35:28] == 8'h00);
      exp_resp = {13'h0, DEC[i][38:28], 5'h00, ~ack, ack, 1'b1};
      check(rd & 32'h0007ff07, exp_resp, "resp");
      rdchk(`N2SCD_OFF_DATA, 32'hff, 32'h0, "data zero");
    end
    for (p = 8'h00; p <= 8'h15; p++) begin
      wr(`N2SCD_OFF_BOWR, {23'h0, 1'b1, p});
    end
    check({16'h0, run_command_word_out}, 32'h81ff, "run word");
    check({31'h0, data_protect_setting_out}, 32'h1, "protect");
    rdchk(`N2SCD_OFF_STAT, 32'h2, 32'h2, "protect status");
    i_n2scd_host_model.request(28'h020d401, rd);
    check(rd & 32'h0007ff07, 32'h00010003, "point status resp");
    rdchk(`N2SCD_OFF_DATA, 32'hff, 32'h1, "point status");
    check({16'h0, universal_output_word_out}, 32'h0, "gated word");
    rdchk(`N2SCD_OFF_UNIW, 32'hffff0000, 32'h011f0000, "raw word");
    wr(`N2SCD_OFF_FSLO, 32'h1b1b1b1b);
    wr(`N2SCD_OFF_FSHI, 32'h00001b1b);
    check({16'h0, universal_output_word_out}, 32'h011f, "selected word");
    wr(`N2SCD_OFF_FSLO, 32'h1b1b1b1a);
    check({16'h0, universal_output_word_out}, 32'h011e, "one deselected");
    for (p = 8'h01; p <= 8'h14; p++) begin
      wr(`N2SCD_OFF_BOWR, {24'h0, p});
    end
    check({15'h0, data_protect_setting_out, run_command_word_out}, 32'h0, "cleared");
    for (p = 8'h00; p <= 8'h2b; p++) begin
      wr(`N2SCD_OFF_GRP, {24'h0, p});
      known = p >= 8'h02 && p <= 8'h29 && !(p inside {8'h09, 8'h0b, 8'h0c, 8'h13, 8'h15,
              8'h16, 8'h1b, 8'h1c, 8'h1f, 8'h21, 8'h22, 8'h23, 8'h26});
      rdchk(`N2SCD_OFF_GRP, 32'h100, {23'h0, known, 8'h00}, "group");
    end
    i_n2scd_host_model.xfer(1'b0, 12'h02c, 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "unmapped");
    check(rd, 32'h0, "unmapped data");
    wr(12'h002, 32'h1);
    check({31'h0, err}, 32'h1, "unaligned");
    wr(`N2SCD_OFF_RUNW, 32'hffff);
    check({16'h0, run_command_word_out}, 32'h0, "read-only word");
    i_n2scd_host_model.set_code(16'hffff, rd);
    check(rd & 32'hffff, 32'hffff, "function code");
    wr(`N2SCD_OFF_BOWR, 32'h00000114);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    check({31'h0, data_protect_setting_out}, 32'h0, "protect after reset");
    reset_n_in <= 1'b1;
    rdchk(`N2SCD_OFF_PFC, 32'hffff, 32'h0, "code after reset");
    finish_test();
  end
endmodule : testbench
